// ### inc/watchdog_pkg.sv
// constants, field layout and mode codes of the watchdog unit
// assumes an apb master on pclk and a 32-bit data path
//
// How it works
// RL1: while enabled, an unserviced timer period ends in a system reset.
// RL2: software must complete a valid service within every programmed period.
// RL3: the watchdog counts with a 16-bit counter.
// RL4: counter tick is the system clock divided by 256 or by 16384.
// RL5: normal mode reloads the software value; other modes reload a fixed value.
// RL6: the init-done lock bit is held here and driven onto a system line.
// RL7: every change of the init-done lock bit is observed and flagged; the code flags service changes only, not the reset to 1.
// RL8: an error first raises the nmi, then resets after a further period.
// RL9: the access password mixes a fixed field with a software-set field.
// RL10: service takes two writes whose spacing is watched and limited.
// RL11: wrong password on write one or wrong guard on write two is an error.
// RL12: counting may be disabled; password check and lock monitoring stay on.
// RL13: two watchdog resets without valid access between hold reset until power-on.
// RL14: a counter overflow in normal mode is an error entering prewarning.
// RL15: a completed two-write service reloads the counter from the software value; the code loads the fixed value on a same-cycle overflow.
package watchdog_pkg;

  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_STAT = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h0c;

  // control word fields
  localparam int F_RELOAD_LSB = 16;
  localparam int F_PW_LSB = 8;
  localparam int F_GUARD_LSB = 4;
  localparam int F_FSEL = 3;
  localparam int F_DIS = 2;
  localparam int F_INIT = 0;

  // status word fields
  localparam int S_CNT_LSB = 16;
  localparam int S_MODE_LSB = 8;
  localparam int S_SEEN = 2;
  localparam int S_OPEN = 1;

  localparam logic [7:0] FIXED_PW = 8'h5a;
  localparam logic [3:0] GUARD = 4'ha;
  localparam logic [7:0] USER_PW_RST = 8'h00;
  localparam logic [15:0] RELOAD_RST = 16'h0000;
  localparam logic [15:0] FIXED_RELOAD = 16'hff00;

  localparam int DIV_FAST = 256;
  localparam int DIV_SLOW = 16384;
  localparam int ACCESS_WINDOW_CYC = 1024;
  localparam int RESET_PULSE_CYC = 16;

  // interrupt status bits
  localparam int IRQ_W = 4;
  localparam int IRQ_PREWARN = 0;
  localparam int IRQ_ACCERR = 1;
  localparam int IRQ_OVF = 2;
  localparam int IRQ_INITCHG = 3;

  typedef enum logic [4:0] {
    M_TIMEOUT = 5'b00001,
    M_NORMAL = 5'b00010,
    M_PREWARN = 5'b00100,
    M_RESET = 5'b01000,
    M_HOLD = 5'b10000
  } mode_t;

endpackage

// ### verilog/wdt_prescaler.sv
// clock divider giving a one-cycle tick every fast or slow division
// assumes run and clear come from logic on pclk
module tick_prescaler #(
  parameter int FAST_DIV = 256,
  parameter int SLOW_DIV = 16384
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic run,
  input wire logic clear,
  input wire logic sel_slow,
  // tick
  output logic tick_q
);

  localparam int CW = $clog2(SLOW_DIV);

  if (FAST_DIV < 2 || SLOW_DIV < FAST_DIV) begin : g_chk
    $error("prescaler divisions out of range");
  end

  localparam logic [CW-1:0] FAST_LAST = CW'(FAST_DIV - 1);
  localparam logic [CW-1:0] SLOW_LAST = CW'(SLOW_DIV - 1);

  logic [CW-1:0] div_q;
  wire [CW-1:0] last = sel_slow ? SLOW_LAST : FAST_LAST;
  // >= so a switch to the fast rate never strands the count above last
  wire wrap = div_q >= last;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q <= (clear || !run || wrap) ? '0 : div_q + 1'b1;
      tick_q <= run && !clear && wrap; // RL4
    end
  end

endmodule

// ### verilog/wdt_counter.sv
// up counter with load; overflow pulse when it wraps past all ones
// assumes load and tick are one-cycle pulses on pclk
module period_counter #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic tick,
  // state
  output logic [W-1:0] count_q,
  output logic ovf_q
);

  if (W < 2) begin : g_chk
    $error("counter width too small");
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= '0;
      ovf_q <= 1'b0;
    end else begin
      // a load beats a tick in the same cycle
      if (load) begin
        count_q <= load_val;
      end else if (tick) begin
        count_q <= count_q + 1'b1; // RL3
      end
      ovf_q <= !load && tick && (&count_q);
    end
  end

endmodule

// ### verilog/watchdog_unit.sv
// watchdog unit: apb register slave, two-write password service,
// prewarning nmi, system reset request and double reset hold
// assumes presetn is the power-on reset and is not driven by sys_reset_q
module watchdog_unit #(
  parameter int CNT_W = 16,
  parameter int FAST_DIV = watchdog_pkg::DIV_FAST,
  parameter int SLOW_DIV = watchdog_pkg::DIV_SLOW,
  parameter int ACCESS_WINDOW = watchdog_pkg::ACCESS_WINDOW_CYC,
  parameter int RESET_PULSE = watchdog_pkg::RESET_PULSE_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [watchdog_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_q,
  output logic pready_q,
  output logic pslverr_q,
  // system lines
  output logic init_done_lock_bit_q,
  output logic nmi_q,
  output logic sys_reset_q,
  output logic irq_q
);

  if (CNT_W != 16) begin : g_chk_w
    $error("reload field holds exactly 16 bits");
  end
  if (ACCESS_WINDOW < 2 || RESET_PULSE < 1) begin : g_chk_t
    $error("window or reset pulse too short");
  end

  localparam int WW = $clog2(ACCESS_WINDOW + 1);
  localparam int RW = $clog2(RESET_PULSE + 1);
  localparam logic [WW-1:0] WIN_LAST = WW'(ACCESS_WINDOW);
  localparam logic [RW-1:0] RST_LAST = RW'(RESET_PULSE - 1);

  // register state
  watchdog_pkg::mode_t mode_q, mode_d;
  logic [15:0] reload_q;
  logic [7:0] user_pw_q;
  logic fsel_q;
  logic dis_q;
  logic open_q;
  logic seen_q;
  logic [WW-1:0] win_q;
  logic [RW-1:0] rst_q;
  logic [watchdog_pkg::IRQ_W-1:0] istat_q, istat_d;
  logic [watchdog_pkg::IRQ_W-1:0] imask_q;

  // counter and prescaler
  logic [CNT_W-1:0] count_q;
  logic ovf_q;
  logic tick_q;

  // apb decode
  wire setup = psel && !penable;
  wire access = psel && penable && pready_q;
  wire wr = access && pwrite;
  wire hit_ctrl = paddr == watchdog_pkg::OFF_CTRL;
  wire hit_stat = paddr == watchdog_pkg::OFF_STAT;
  wire hit_istat = paddr == watchdog_pkg::OFF_IRQ_STAT;
  wire hit_imask = paddr == watchdog_pkg::OFF_IRQ_MASK;
  wire hit_any = hit_ctrl || hit_stat || hit_istat || hit_imask;
  wire wr_ctrl = wr && hit_ctrl;
  wire wr_istat = wr && hit_istat;
  wire wr_imask = wr && hit_imask;

  // mode decode
  wire m_timeout = mode_q == watchdog_pkg::M_TIMEOUT;
  wire m_normal = mode_q == watchdog_pkg::M_NORMAL;
  wire m_prewarn = mode_q == watchdog_pkg::M_PREWARN;
  wire m_reset = mode_q == watchdog_pkg::M_RESET;
  wire m_active = m_timeout || m_normal;

  // password and guard checks
  wire [7:0] pw_field = pwdata[watchdog_pkg::F_PW_LSB +: 8];
  wire [7:0] fix_field = pwdata[7:0];
  wire [3:0] guard_field = pwdata[watchdog_pkg::F_GUARD_LSB +: 4];
  wire pw_ok = pw_field == user_pw_q &&
               fix_field == watchdog_pkg::FIXED_PW; // RL9
  wire guard_ok = guard_field == watchdog_pkg::GUARD;

  // access sequence: protection stays on even while counting is disabled
  wire first_wr = wr_ctrl && m_active && !open_q; // RL12
  wire second_wr = wr_ctrl && m_active && open_q;
  wire unlock = first_wr && pw_ok;
  wire service = second_wr && guard_ok; // RL10
  wire acc_err = (first_wr && !pw_ok) ||
                 (second_wr && !guard_ok); // RL11
  wire win_over = open_q && !wr_ctrl && win_q == WIN_LAST; // RL10

  // new control values from the second write
  wire new_init = pwdata[watchdog_pkg::F_INIT];
  wire new_dis = pwdata[watchdog_pkg::F_DIS];
  wire new_fsel = pwdata[watchdog_pkg::F_FSEL];
  wire [15:0] new_reload = pwdata[watchdog_pkg::F_RELOAD_LSB +: 16];
  wire init_chg = service && new_init != init_done_lock_bit_q; // RL7

  // errors: overflow in time-out or normal mode, or a bad access
  wire ovf_err = ovf_q && m_active; // RL14
  wire err = acc_err || ovf_err; // RL8
  wire pre_end = ovf_q && m_prewarn; // RL1
  wire rst_end = m_reset && rst_q == RST_LAST;

  // counter control
  wire run = m_timeout || m_prewarn || (m_normal && !dis_q); // RL12
  wire cnt_load = service || err || rst_end;
  // a service in time-out mode leaves it for normal mode
  wire [15:0] load_val = (service && !err) ? new_reload :
                         watchdog_pkg::FIXED_RELOAD; // RL5 RL15

  // mode sequencing
  always_comb begin
    mode_d = mode_q;
    unique case (mode_q)
      watchdog_pkg::M_TIMEOUT,
      watchdog_pkg::M_NORMAL: begin
        if (err) begin
          mode_d = watchdog_pkg::M_PREWARN; // RL8
        end else if (service) begin
          mode_d = watchdog_pkg::M_NORMAL;
        end
      end
      watchdog_pkg::M_PREWARN: begin
        if (pre_end) begin
          // second watchdog reset with no valid access since the first
          mode_d = seen_q ? watchdog_pkg::M_HOLD :
                            watchdog_pkg::M_RESET; // RL13
        end
      end
      watchdog_pkg::M_RESET: begin
        if (rst_end) begin
          mode_d = watchdog_pkg::M_TIMEOUT;
        end
      end
      watchdog_pkg::M_HOLD: begin
        // left only by power-on reset
        mode_d = watchdog_pkg::M_HOLD; // RL13
      end
      default: begin
        mode_d = watchdog_pkg::M_HOLD;
      end
    endcase
  end

  // interrupt status: a hardware set wins over a software clear
  wire [watchdog_pkg::IRQ_W-1:0] ev;
  assign ev[watchdog_pkg::IRQ_PREWARN] = err && m_active;
  assign ev[watchdog_pkg::IRQ_ACCERR] = acc_err;
  assign ev[watchdog_pkg::IRQ_OVF] = ovf_err;
  assign ev[watchdog_pkg::IRQ_INITCHG] = init_chg; // RL7
  wire [watchdog_pkg::IRQ_W-1:0] iclr =
    wr_istat ? pwdata[watchdog_pkg::IRQ_W-1:0] : '0;
  assign istat_d = (istat_q & ~iclr) | ev;

  // read data
  wire [31:0] ctrl_rd = {reload_q, 12'h000, fsel_q, dis_q, 1'b0,
                         init_done_lock_bit_q};
  wire [31:0] stat_rd = {count_q, 3'h0, mode_q, 5'h00, seen_q, open_q,
                         1'b0};
  wire [31:0] istat_rd = {{(32 - watchdog_pkg::IRQ_W){1'b0}}, istat_q};
  wire [31:0] imask_rd = {{(32 - watchdog_pkg::IRQ_W){1'b0}}, imask_q};
  wire [31:0] rd_mux = hit_ctrl ? ctrl_rd :
                       hit_stat ? stat_rd :
                       hit_istat ? istat_rd :
                       hit_imask ? imask_rd : 32'h0000_0000;

  // apb answer: ready in the first access cycle, no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup && !hit_any;
      prdata_q <= (setup && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // mode, reset pulse and nmi
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= watchdog_pkg::M_TIMEOUT;
      rst_q <= '0;
      nmi_q <= 1'b0;
      sys_reset_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      rst_q <= m_reset ? rst_q + 1'b1 : '0;
      // nmi stands for the whole prewarning period
      nmi_q <= mode_d == watchdog_pkg::M_PREWARN; // RL8
      sys_reset_q <= mode_d == watchdog_pkg::M_RESET ||
                     mode_d == watchdog_pkg::M_HOLD; // RL1 RL13
    end
  end

  // double reset memory survives the watchdog reset it counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_q <= 1'b0;
    end else if (service) begin
      seen_q <= 1'b0; // RL13
    end else if (pre_end) begin
      seen_q <= 1'b1; // RL13
    end
  end

  // access window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      open_q <= 1'b0;
      win_q <= '0;
    end else begin
      if (unlock) begin
        open_q <= 1'b1;
      end else if (second_wr || win_over || !m_active) begin
        open_q <= 1'b0;
      end
      win_q <= (unlock || !open_q) ? '0 : win_q + 1'b1;
    end
  end

  // control fields, restored to defaults by a watchdog reset too
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_done_lock_bit_q <= 1'b1;
      dis_q <= 1'b0;
      fsel_q <= 1'b0;
      reload_q <= watchdog_pkg::RELOAD_RST;
      user_pw_q <= watchdog_pkg::USER_PW_RST;
    end else if (rst_end) begin
      init_done_lock_bit_q <= 1'b1;
      dis_q <= 1'b0;
      fsel_q <= 1'b0;
      reload_q <= watchdog_pkg::RELOAD_RST;
      user_pw_q <= watchdog_pkg::USER_PW_RST;
    end else if (service) begin
      init_done_lock_bit_q <= new_init; // RL6
      dis_q <= new_dis; // RL12
      fsel_q <= new_fsel; // RL4
      reload_q <= new_reload; // RL5
      user_pw_q <= pw_field; // RL9
    end
  end

  // interrupt registers and output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_q <= '0;
      imask_q <= '0;
      irq_q <= 1'b0;
    end else begin
      istat_q <= istat_d;
      if (wr_imask) begin
        imask_q <= pwdata[watchdog_pkg::IRQ_W-1:0];
      end
      irq_q <= |(istat_d & (wr_imask ?
               pwdata[watchdog_pkg::IRQ_W-1:0] : imask_q));
    end
  end

  tick_prescaler #(
    .FAST_DIV(FAST_DIV),
    .SLOW_DIV(SLOW_DIV)
  ) u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .run(run),
    .clear(cnt_load),
    .sel_slow(fsel_q),
    .tick_q(tick_q)
  );

  period_counter #(
    .W(CNT_W)
  ) u_counter (
    .pclk(pclk),
    .presetn(presetn),
    .load(cnt_load),
    .load_val(load_val),
    .tick(tick_q && run),
    .count_q(count_q),
    .ovf_q(ovf_q)
  );

endmodule

// ### bench/watchdog_unit_chk.sv
// assertions on the watchdog unit ports
// assumes a bind to watchdog_unit with a reset pulse of 16 cycles
module watchdog_unit_chk (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [watchdog_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata_q,
  input wire logic pready_q,
  input wire logic pslverr_q,
  // system lines
  input wire logic init_done_lock_bit_q,
  input wire logic nmi_q,
  input wire logic sys_reset_q,
  input wire logic irq_q
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire ctrl_wr = psel && penable && pready_q && pwrite && paddr == 8'h00;
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence pulse_s;
    sys_reset_q [*8] ##1 sys_reset_q [*8];
  endsequence
  ready_answer_a: assert property (setup_s |=> pready_q)
    else $error("no pready after setup");
  ready_pulse_a: assert property (pready_q |=> !pready_q)
    else $error("pready longer than one cycle");
  err_ready_a: assert property (pslverr_q |-> pready_q)
    else $error("pslverr without pready");
  rdata_idle_a: assert property (!pready_q |-> prdata_q == 32'h0)
    else $error("read data outside access");
  nmi_first_a: assert property ($rose(sys_reset_q) |-> $past(nmi_q))
    else $error("reset without nmi first");
  reset_len_a: assert property ($rose(sys_reset_q) |-> pulse_s)
    else $error("system reset too short");
  nmi_alone_a: assert property (nmi_q |-> !sys_reset_q)
    else $error("nmi together with reset");
  prewarn_len_a: assert property ($rose(nmi_q) |-> nmi_q [*8])
    else $error("prewarning too short");
  lock_cause_a: assert property ($changed(init_done_lock_bit_q) |->
    $past(ctrl_wr) || $past(sys_reset_q))
    else $error("lock line changed without cause");
endmodule

// ### bench/wdt_host.sv
// host cpu model: apb master and the two-write service
// assumes one calling process at a time
module apb_host (
  // clock
  input wire logic pclk,
  // answer
  input wire logic pready_q,
  input wire logic pslverr_q,
  input wire logic [31:0] prdata_q,
  // request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready_q !== 1'b1);
    rd = prdata_q;
    err = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
    // stale data must not look valid once released
    pwdata <= ~d;
  endtask
  // second write follows at once so the access window cannot lapse
  task automatic service(input logic [7:0] pw, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    xfer(1'b1, 8'h00, {16'h0, pw, 8'h5a}, rd, err);
    xfer(1'b1, 8'h00, d, rd, err);
  endtask
endmodule

// ### bench/watchdog_unit_tb_top.sv
// self-checking bench for the watchdog unit
// assumes host model and checker are compiled first
module watchdog_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk;
  logic presetn;
  wire psel;
  wire penable;
  wire pwrite;
  wire [7:0] paddr;
  wire [31:0] pwdata;
  wire [31:0] prdata_q;
  wire pready_q;
  wire pslverr_q;
  wire lock;
  wire nmi_q;
  wire sys_reset_q;
  wire irq_q;
  int failures = 0;
  int checked = 0;
  int cyc = 0;
  int t0;
  logic [31:0] rd;
  logic err;
  // short divisions keep the overflow paths within a few thousand cycles
  watchdog_unit #(.FAST_DIV(2), .SLOW_DIV(4), .ACCESS_WINDOW(8)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
    .init_done_lock_bit_q(lock), .nmi_q(nmi_q),
    .sys_reset_q(sys_reset_q), .irq_q(irq_q));
  apb_host i_host (.pclk(pclk), .pready_q(pready_q),
    .pslverr_q(pslverr_q), .prdata_q(prdata_q), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      failures++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(input string n, input logic [31:0] s,
      input logic [31:0] e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, a, d, rd, err);
  endtask
  task automatic rdchk(input string n, input logic [7:0] a,
      input logic [31:0] m, input logic [31:0] e);
    i_host.xfer(1'b0, a, 32'h0, rd, err);
    check(n, rd & m, e);
  endtask
  task automatic wait_hi(input bit r, input int lim);
    int n;
    n = 0;
    while ((r ? sys_reset_q : nmi_q) !== 1'b1 && n < lim) begin
      @(posedge pclk);
      n++;
    end
    check(r ? "reset wait" : "nmi wait", {31'h0, n < lim}, 32'h1);
  endtask
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  initial begin
    presetn = 1'b0;
    do_reset();
    rdchk("ctrl", 8'h00, '1, 32'h1);
    check("lock", {31'h0, lock}, 32'h1);
    rdchk("mode", 8'h04, 32'h1f00, 32'h0100);
    rdchk("unmapped", 8'h10, '1, 32'h0);
    check("slverr", {31'h0, err}, 32'h1);
    $display("test reset values done");
    wr(8'h0c, 32'h1);
    wr(8'h00, 32'h0000_005a);
    rdchk("open", 8'h04, 32'h2, 32'h2);
    wr(8'h00, 32'hfff0_3ca8);
    t0 = cyc;
    rdchk("normal", 8'h04, 32'hfff0_1f00, 32'hfff0_0200);
    check("lock", {31'h0, lock}, 32'h0);
    rdchk("ctrl", 8'h00, '1, 32'hfff0_0008);
    rdchk("lock change", 8'h08, 32'h8, 32'h8);
    $display("test service done");
    wait_hi(0, 200);
    check("ovf time", {31'h0, cyc - t0 inside {[62:70]}}, 32'h1);
    rdchk("prewarn", 8'h04, 32'h1f00, 32'h0400);
    rdchk("ovf irq", 8'h08, 32'h5, 32'h5);
    check("irq", {31'h0, irq_q}, 32'h1);
    wr(8'h08, 32'hf);
    @(posedge pclk);
    check("irq clr", {31'h0, irq_q}, 32'h0);
    wait_hi(1, 1200);
    t0 = cyc;
    while (sys_reset_q === 1'b1) @(posedge pclk);
    check("pulse", 32'(cyc - t0), 32'd16);
    check("relock", {31'h0, lock}, 32'h1);
    rdchk("ctrl rst", 8'h00, '1, 32'h1);
    $display("test prewarning done");
    wait_hi(1, 1500);
    repeat (40) @(posedge pclk);
    check("hold", {31'h0, sys_reset_q}, 32'h1);
    rdchk("hold mode", 8'h04, 32'h1f04, 32'h1004);
    $display("test double reset done");
    do_reset();
    i_host.service(8'h00, 32'hfff0_00a4);
    repeat (100) @(posedge pclk);
    check("disabled", {31'h0, nmi_q}, 32'h0);
    rdchk("frozen", 8'h04, 32'hffff_0000, 32'hfff0_0000);
    wr(8'h00, 32'h0000_115a);
    wait_hi(0, 4);
    rdchk("acc err", 8'h08, 32'h2, 32'h2);
    $display("test disable and password done");
    do_reset();
    wr(8'h00, 32'h0000_005a);
    // an idle window relocks silently, with no prewarning
    repeat (12) @(posedge pclk);
    rdchk("window", 8'h04, 32'h1f02, 32'h0100);
    wr(8'h00, 32'h0000_005a);
    wr(8'h00, 32'hfff0_0050);
    wait_hi(0, 4);
    $display("test guard done");
    end_sim();
  end
endmodule
bind watchdog_unit watchdog_unit_chk i_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q),
  .pslverr_q(pslverr_q), .init_done_lock_bit_q(init_done_lock_bit_q),
  .nmi_q(nmi_q), .sys_reset_q(sys_reset_q), .irq_q(irq_q));
